// file: verilog/rom_pkg.sv
// rom_pkg: shared constants and carrier types for the remote terminal message handler.
// assumes a word-level front end (decoder/encoder) outside this block on the same clock.
package rom_pkg;
	// command word field widths and special values
	localparam int ROM_ADDR_W = 5;
	localparam int ROM_SA_W = 5;
	localparam int ROM_WC_W = 5;
	localparam int ROM_DATA_W = 16;
	localparam logic [4:0] ROM_ADDR_BCAST = 5'h1F;
	localparam logic [4:0] ROM_SA_MODE_LO = 5'h00;
	localparam logic [4:0] ROM_SA_MODE_HI = 5'h1F;
	localparam logic [4:0] ROM_SA_WRAP = 5'h1E;
	// a word count field of zero means 32 words
	localparam int ROM_MAX_WORDS = 32;
	localparam int ROM_IDX_W = 6;
	// first data word timeout for a receiver in a peer-to-peer transfer
	localparam int ROM_CLK_NS = 10;
	localparam int ROM_GAP_NOM_NS = 57000;
	localparam int ROM_GAP_TOL_NS = 3000;
	// longest allowed wait, rounded down to whole cycles
	localparam int ROM_GAP_CYC = (ROM_GAP_NOM_NS + ROM_GAP_TOL_NS) / ROM_CLK_NS;
	localparam int ROM_GAP_W = 13;

	// decoded command word as presented by the front end
	typedef struct packed {
		logic [4:0] addr;
		logic tx;
		logic [4:0] sa;
		logic [4:0] wc;
	} rom_cmd_t;

	// status bits that this block owns
	typedef struct packed {
		logic msg_err;
		logic bcast_rx;
		logic busy;
		logic ss_flag;
		logic term_flag;
	} rom_stat_t;

	// receive and transmit message phases
	typedef enum logic [2:0] {
		ROM_IDLE = 3'b000,
		ROM_WAIT_TXCMD = 3'b001,
		ROM_WAIT_PSTAT = 3'b010,
		ROM_RX_DATA = 3'b011,
		ROM_TX_DATA = 3'b100
	} rom_state_t;
endpackage : rom_pkg

// file: verilog/rom_wrap_buf.sv
// rom_wrap_buf: wrap-around word store; the stored receive word count is kept in the handler.
// assumes writes and reads arrive from the message sequencer on one clock.
`timescale 1ns/1ns
`default_nettype none
module rom_wrap_buf (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// write side
	input wire logic wr_en_i,
	input wire logic [rom_pkg::ROM_IDX_W-1:0] wr_idx_i,
	input wire logic [rom_pkg::ROM_DATA_W-1:0] wr_data_i,
	// read side
	input wire logic [rom_pkg::ROM_IDX_W-1:0] rd_idx_i,
	output logic [rom_pkg::ROM_DATA_W-1:0] rd_data_o
);
	import rom_pkg::*;
	// flip-flop storage, one entry per possible data word
	logic [ROM_DATA_W-1:0] mem_r [ROM_MAX_WORDS];
	// each entry is written only by its own index, any bit pattern kept
	genvar gi;
	generate
		for (gi = 0; gi < ROM_MAX_WORDS; gi++) begin : g_ent
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					mem_r[gi] <= '0;
				end else if (wr_en_i && wr_idx_i == ROM_IDX_W'(gi)) begin
					mem_r[gi] <= wr_data_i;
				end
			end
		end
	endgenerate
	// registered read keeps data outputs off combinational paths
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= mem_r[rd_idx_i[4:0]];
		end
	end
endmodule : rom_wrap_buf
`default_nettype wire

// file: verilog/rom_msg_handler.sv
// rom_msg_handler: message option handling of a remote terminal: busy, broadcast,
// wrap-around, format neutrality and peer-to-peer receive timeout.
// assumes a word-level decoder that hands over validated words as one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - busy conditions reported in status busy bit
// - command busy set only by commands to us
// - failures may also set busy with flags
// - tell broadcast from addressed same subaddress
// - address 11111 only ever means broadcast
// - wrap receive accepts one to N words
// - wrap transmit sends one to N words
// - wrap transmit echoes received words exactly
// - use subaddress 30 for wrap-around
// - support transfers both ways, peer, mode (mode commands start no transfer here, they only update status and drop a wrap pairing)
// - receive data handled same in any format
// - transmit data sourced same in any format
// - late first peer data word invalidates message
// - check peer transmit command and status first
module rom_msg_handler (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// terminal configuration
	input wire logic [rom_pkg::ROM_ADDR_W-1:0] own_addr_i,
	input wire logic bcast_en_i,
	// word stream from the decoder (same clock)
	input wire logic cmd_vld_i,
	input wire rom_pkg::rom_cmd_t cmd_i,
	input wire logic stat_vld_i,
	input wire logic data_vld_i,
	input wire logic [rom_pkg::ROM_DATA_W-1:0] data_i,
	input wire logic word_err_i,
	// subsystem conditions
	input wire logic ss_busy_i,
	input wire logic ss_fail_i,
	input wire logic term_fail_i,
	input wire logic busy_on_fail_i,
	// transmit request from the encoder
	input wire logic tx_rdy_i,
	// outputs
	output rom_pkg::rom_stat_t stat_o,
	output logic msg_ok_o,
	output logic rx_wr_o,
	output logic [rom_pkg::ROM_SA_W-1:0] rx_sa_o,
	output logic [rom_pkg::ROM_DATA_W-1:0] rx_data_o,
	output logic tx_vld_o,
	output logic tx_wrap_o,
	output logic [rom_pkg::ROM_DATA_W-1:0] tx_data_o
);
	import rom_pkg::*;
	// reset released through two flops
	logic rst_s1_r, rst_n_r;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end
	// sequencer state
	rom_state_t st_r, st_nxt;
	rom_cmd_t cur_r; // command being served
	logic bcast_r; // current message came broadcast
	logic [ROM_IDX_W-1:0] cnt_r; // words moved so far
	logic [ROM_IDX_W-1:0] wrap_cnt_r; // stored wrap receive count
	logic wrap_ok_r; // a wrap receive is pending for echo
	logic [ROM_GAP_W-1:0] gap_r; // cycles waited for first peer data
	logic busy_cmd_r; // busy caused by a command
	logic bcast_flag_r; // broadcast received status flag
	logic err_r; // message error status flag
	// address and command decode
	wire is_bcast = (cmd_i.addr == ROM_ADDR_BCAST) && bcast_en_i;
	wire own_ok = (own_addr_i != ROM_ADDR_BCAST);
	wire is_own = own_ok && (cmd_i.addr == own_addr_i);
	wire for_us = cmd_vld_i && (is_own || is_bcast);
	wire is_mode = (cmd_i.sa == ROM_SA_MODE_LO) || (cmd_i.sa == ROM_SA_MODE_HI);
	// broadcast non-mode transmit is illegal and simply not answered
	wire bad_bcast = is_bcast && cmd_i.tx;
	wire [ROM_IDX_W-1:0] cmd_words = (cmd_i.wc == '0) ? ROM_IDX_W'(ROM_MAX_WORDS)
		: {1'b0, cmd_i.wc};
	wire [ROM_IDX_W-1:0] cur_words = (cur_r.wc == '0) ? ROM_IDX_W'(ROM_MAX_WORDS)
		: {1'b0, cur_r.wc};
	// a receive command immediately followed by a transmit command to another RT
	wire peer_tx = cmd_vld_i && cmd_i.tx && !is_own && !(cmd_i.addr == ROM_ADDR_BCAST);
	wire is_wrap_sa = (cur_r.sa == ROM_SA_WRAP);
	wire last_word = (cnt_r + 6'h01) == cur_words;
	wire gap_late = (gap_r == ROM_GAP_W'(ROM_GAP_CYC));
	// echo allowed only for same count with nothing in between
	wire wrap_hit = wrap_ok_r && is_wrap_sa && (cur_words == wrap_cnt_r);
	// only a wrap transmit of the stored count may keep the pairing alive
	wire wrap_keep = cmd_i.tx && (cmd_i.sa == ROM_SA_WRAP) && (cmd_words == wrap_cnt_r);
	// next state decode
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ROM_IDLE: begin
				if (for_us && !is_mode && !bad_bcast) begin
					st_nxt = cmd_i.tx ? ROM_TX_DATA : ROM_WAIT_TXCMD;
				end
			end
			ROM_WAIT_TXCMD: begin
				// a peer transmit command means a peer-to-peer receive
				if (peer_tx) begin
					st_nxt = ROM_WAIT_PSTAT;
				end else if (data_vld_i) begin
					// a one-word message is already complete here, so never park in data phase
					st_nxt = last_word ? ROM_IDLE : ROM_RX_DATA;
				end else if (word_err_i || for_us) begin
					st_nxt = ROM_IDLE;
				end
			end
			ROM_WAIT_PSTAT: begin
				if (stat_vld_i) begin
					st_nxt = ROM_RX_DATA;
				end else if (data_vld_i || gap_late || word_err_i) begin
					st_nxt = ROM_IDLE;
				end
			end
			ROM_RX_DATA: begin
				if (word_err_i || (gap_late && cnt_r == '0)) begin
					st_nxt = ROM_IDLE;
				end else if (data_vld_i && last_word) begin
					st_nxt = ROM_IDLE;
				end
			end
			ROM_TX_DATA: begin
				if (tx_rdy_i && last_word) begin
					st_nxt = ROM_IDLE;
				end
			end
			default: st_nxt = ROM_IDLE;
		endcase
	end
	// first word of a receive is counted from the first data after command
	wire rx_take = data_vld_i && ((st_r == ROM_RX_DATA) || (st_r == ROM_WAIT_TXCMD));
	wire rx_done = rx_take && last_word && !word_err_i;
	// any drop to idle from these phases other than a completed receive is a failure,
	// so the error flag always agrees with the state actually taken
	wire rx_fail = (st_r inside {ROM_RX_DATA, ROM_WAIT_PSTAT})
		&& (st_nxt == ROM_IDLE) && !rx_done;
	wire tx_step = (st_r == ROM_TX_DATA) && tx_rdy_i;
	// sequencer registers
	always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= ROM_IDLE;
			cur_r <= '0;
			bcast_r <= 1'b0;
			cnt_r <= '0;
			gap_r <= '0;
		end else begin
			st_r <= st_nxt;
			if (st_r == ROM_IDLE && for_us) begin
				cur_r <= cmd_i;
				bcast_r <= is_bcast;
			end
			if (st_nxt == ROM_IDLE || (st_r == ROM_WAIT_PSTAT && stat_vld_i)) begin
				cnt_r <= '0;
			end else if (rx_take || tx_step) begin
				cnt_r <= cnt_r + 6'h01;
			end
			// timeout counts from the receive command until first data
			if (st_r == ROM_IDLE || cnt_r != '0 || data_vld_i) begin
				gap_r <= '0;
			end else if (!gap_late) begin
				gap_r <= gap_r + 13'h0001;
			end
		end
	end
	// wrap-around pairing and status flags
	always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wrap_ok_r <= 1'b0;
			wrap_cnt_r <= '0;
			busy_cmd_r <= 1'b0;
			bcast_flag_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			if (rx_done && is_wrap_sa && !bcast_r) begin
				wrap_ok_r <= 1'b1;
				wrap_cnt_r <= cnt_r + 6'h01;
			end else if (st_r == ROM_IDLE && for_us && !wrap_keep) begin
				wrap_ok_r <= 1'b0;
			end else if (tx_step && last_word) begin
				wrap_ok_r <= 1'b0;
			end
			// busy may only begin when a command to us is taken
			if (st_r == ROM_IDLE && for_us) begin
				busy_cmd_r <= ss_busy_i;
				bcast_flag_r <= is_bcast;
				err_r <= 1'b0;
			end
			if (rx_fail) begin
				err_r <= 1'b1;
			end
		end
	end
	// status word bits, busy from commands or failure
	wire fail_busy = busy_on_fail_i && (ss_fail_i || term_fail_i);
	assign stat_o = '{msg_err: err_r, bcast_rx: bcast_flag_r,
		busy: busy_cmd_r || fail_busy, ss_flag: ss_fail_i, term_flag: term_fail_i};
	assign msg_ok_o = rx_done;
	// received words go to the subaddress regardless of format
	assign rx_wr_o = rx_take && !word_err_i;
	assign rx_sa_o = cur_r.sa;
	assign rx_data_o = data_i;
	// transmit words come from the same source whatever the format
	assign tx_vld_o = (st_r == ROM_TX_DATA);
	assign tx_wrap_o = tx_vld_o && wrap_hit;
	// wrap store
	wire [ROM_IDX_W-1:0] rd_idx = tx_step ? (cnt_r + 6'h01) : cnt_r;
	rom_wrap_buf u_wrap (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_r),
		.wr_en_i(rx_take && is_wrap_sa && !bcast_r),
		.wr_idx_i(cnt_r),
		.wr_data_i(data_i),
		.rd_idx_i(rd_idx),
		.rd_data_o(tx_data_o)
	);
	// checks
	property p_late_first;
		@(posedge clk_sys_i) disable iff (!rst_n_r)
		(st_r == ROM_RX_DATA && cnt_r == '0 && gap_late && !data_vld_i) |=> (st_r == ROM_IDLE && err_r);
	endproperty
	a_late_first: assert property (p_late_first) else $error("late data not rejected");
	property p_busy_cause;
		@(posedge clk_sys_i) disable iff (!rst_n_r)
		$rose(busy_cmd_r) |-> $past(for_us && st_r == ROM_IDLE);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
	property p_busy_out;
		@(posedge clk_sys_i) disable iff (!rst_n_r)
		fail_busy |-> stat_o.busy;
	endproperty
	a_busy_out: assert property (p_busy_out) else $error("failure busy missing");
	property p_bcast_tag;
		@(posedge clk_sys_i) disable iff (!rst_n_r)
		(st_r == ROM_IDLE && cmd_vld_i && is_bcast && !is_own) |=> bcast_flag_r;
	endproperty
	a_bcast_tag: assert property (p_bcast_tag) else $error("broadcast not flagged");
	property p_no_bcast_tx;
		@(posedge clk_sys_i) disable iff (!rst_n_r)
		(st_r == ROM_IDLE && cmd_vld_i && bad_bcast) |=> st_r == ROM_IDLE;
	endproperty
	a_no_bcast_tx: assert property (p_no_bcast_tx) else $error("broadcast transmit taken");
	property p_tx_len;
		@(posedge clk_sys_i) disable iff (!rst_n_r)
		(st_r == ROM_TX_DATA) |-> cnt_r < cur_words;
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("transmit overrun");
	property p_wrap_drop;
		@(posedge clk_sys_i) disable iff (!rst_n_r)
		(st_r == ROM_IDLE && for_us && !cmd_i.tx) |=> !wrap_ok_r;
	endproperty
	a_wrap_drop: assert property (p_wrap_drop) else $error("pairing kept");
	property p_rx_write;
		@(posedge clk_sys_i) disable iff (!rst_n_r)
		(st_r == ROM_RX_DATA && data_vld_i && !word_err_i) |-> rx_wr_o && rx_data_o == data_i;
	endproperty
	a_rx_write: assert property (p_rx_write) else $error("receive word lost");
endmodule : rom_msg_handler
`default_nettype wire

// file: verif/rom_bc_model.sv
// rom_bc_model: controller and peer terminal feeding validated words to the handler.
// assumes the handler samples on the rising edge; words are driven just after it.
`timescale 1ns/1ns
`default_nettype none
module rom_bc_model (
	// clock
	input wire logic clk_sys_i,
	// word stream to the handler
	output logic cmd_vld_o,
	output rom_pkg::rom_cmd_t cmd_o,
	output logic stat_vld_o,
	output logic data_vld_o,
	output logic [15:0] data_o,
	output logic word_err_o,
	// encoder side
	input wire logic tx_vld_i,
	output logic tx_rdy_o
);
	import rom_pkg::*;
	int rdy_gap = 0; // extra cycles before the encoder takes a word
	initial begin
		cmd_vld_o = 1'b0;
		cmd_o = '0;
		stat_vld_o = 1'b0;
		data_vld_o = 1'b0;
		data_o = 16'h0000;
		word_err_o = 1'b0;
		tx_rdy_o = 1'b0;
	end
	// one word per call (0 command, 1 status, 2 data, 3 failed word); any format can be sent
	task automatic put(input int kind, input logic [15:0] w);
		@(posedge clk_sys_i);
		#1;
		cmd_o = w;
		data_o = w;
		cmd_vld_o = (kind == 0);
		stat_vld_o = (kind == 1);
		data_vld_o = (kind == 2);
		word_err_o = (kind == 3);
		@(posedge clk_sys_i);
		#1;
		cmd_vld_o = 1'b0;
		stat_vld_o = 1'b0;
		data_vld_o = 1'b0;
		word_err_o = 1'b0;
		data_o = ~w; // a released line must not look like the old word
	endtask : put
	// encoder takes words one by one, optionally slowly
	always begin
		@(posedge clk_sys_i);
		#1;
		if (tx_vld_i === 1'b1) begin
			repeat (rdy_gap + 1) @(posedge clk_sys_i);
			#1;
			tx_rdy_o = 1'b1;
			@(posedge clk_sys_i);
			#1;
			tx_rdy_o = 1'b0;
		end
	end
endmodule : rom_bc_model
`default_nettype wire

// file: verif/rom_msg_handler_tb_top.sv
// rom_msg_handler_tb_top: self-checking bench for the message handler.
// assumes the design holds its own assertions; this bench checks words and status.
`timescale 1ns/1ns
`default_nettype none
module rom_msg_handler_tb_top;
	import rom_pkg::*;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [4:0] own = 5'h05; // terminal address, never the broadcast one
	logic bcast_en = 1'b0;
	logic ss_busy = 1'b0;
	logic ss_fail = 1'b0;
	logic term_fail = 1'b0;
	logic bof = 1'b0;
	logic cmd_vld, stat_vld, data_vld, word_err, tx_rdy, msg_ok, rx_wr, tx_vld, tx_wrap;
	rom_cmd_t cmd;
	rom_stat_t stat;
	logic [4:0] rx_sa;
	logic [15:0] data, rx_data, tx_data;
	logic [15:0] wbuf [32]; // copy of the words last sent to this terminal's address, any subaddress
	logic [20:0] rq [$]; // expected received words
	logic [16:0] tq [$]; // expected transmitted words
	int err_total = 0;
	int samples_checked = 0;
	int oks = 0;
	int exp_oks = 0;
	int cyc = 0;
	int pair_n = 0;
	int k;
	integer seed = 32'hd970fa6c;
	always #5 clk_sys_i = ~clk_sys_i;
	rom_msg_handler u_rom_msg_handler (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.own_addr_i(own), .bcast_en_i(bcast_en), .cmd_vld_i(cmd_vld), .cmd_i(cmd),
		.stat_vld_i(stat_vld), .data_vld_i(data_vld), .data_i(data), .word_err_i(word_err),
		.ss_busy_i(ss_busy), .ss_fail_i(ss_fail), .term_fail_i(term_fail),
		.busy_on_fail_i(bof), .tx_rdy_i(tx_rdy), .stat_o(stat), .msg_ok_o(msg_ok),
		.rx_wr_o(rx_wr), .rx_sa_o(rx_sa), .rx_data_o(rx_data), .tx_vld_o(tx_vld),
		.tx_wrap_o(tx_wrap), .tx_data_o(tx_data));
	rom_bc_model u_rom_bc_model (.clk_sys_i(clk_sys_i), .cmd_vld_o(cmd_vld), .cmd_o(cmd),
		.stat_vld_o(stat_vld), .data_vld_o(data_vld), .data_o(data), .word_err_o(word_err),
		.tx_vld_i(tx_vld), .tx_rdy_o(tx_rdy));
	task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	// settle just after an edge so inputs never race the sampling edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : step
	// receive message, optionally as peer transfer, with a wait before the data
	task automatic rx_msg(input logic [4:0] a, input logic [4:0] sa, input int n,
		input bit peer, input int gap);
		logic [15:0] w;
		bit tk;
		tk = (a == own) || (bcast_en && a == ROM_ADDR_BCAST);
		u_rom_bc_model.put(0, {a, 1'b0, sa, n[4:0]});
		if (peer) begin
			u_rom_bc_model.put(0, {5'h0A, 1'b1, sa, n[4:0]});
			u_rom_bc_model.put(1, 16'h5000);
		end
		step(gap);
		for (int i = 0; i < n; i++) begin
			w = $random(seed);
			if (tk && gap < 5990) rq.push_back({sa, w});
			if (a == own) wbuf[i] = w;
			u_rom_bc_model.put(2, w);
		end
		if (tk) pair_n = (a == own && sa == ROM_SA_WRAP && gap < 5990) ? n : 0;
		if (tk && gap < 5990) exp_oks++;
		step(2);
	endtask : rx_msg
	// transmit message; echo expected only for a standing wrap pairing
	task automatic tx_msg(input logic [4:0] sa, input int n);
		bit wr;
		wr = (sa == ROM_SA_WRAP) && pair_n == n;
		for (int i = 0; i < n; i++) tq.push_back({wr, wr ? wbuf[i] : 16'h0000});
		u_rom_bc_model.put(0, {own, 1'b1, sa, n[4:0]});
		pair_n = 0;
		for (int i = 0; i < 2000 && (tx_vld === 1'b1 || tq.size() > 0); i++) step(1);
		chk(tq.size(), 0);
		tq.delete();
	endtask : tx_msg
	// result watcher and hang limit
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc > 60000) begin
			err_total++;
			report_and_stop();
		end
		if (msg_ok === 1'b1) oks++;
		if (rx_wr === 1'b1) chk({rx_sa, rx_data}, rq.size() ? rq.pop_front() : 21'h1FFFFF);
		if (tx_rdy === 1'b1) chk({tx_wrap, tx_wrap ? tx_data : 16'h0000},
			tq.size() ? tq.pop_front() : 17'h1FFFF);
	end
	initial begin
		step(20);
		resetn_i = 1'b1;
		step(5);
		// busy follows only commands taken by this terminal
		ss_busy = 1'b1;
		rx_msg(5'h0A, 5'h01, 1, 0, 0);
		chk(stat.busy, 0);
		rx_msg(own, 5'h01, 1, 0, 0);
		chk(stat.busy, 1);
		ss_busy = 1'b0;
		rx_msg(own, 5'h01, 1, 0, 0);
		chk(stat.busy, 0);
		// every mix of failure flags, with and without busy
		for (int i = 0; i < 8; i++) begin
			{ss_fail, term_fail, bof} = i[2:0];
			step(1);
			chk(stat[2:0], {bof & (ss_fail | term_fail), ss_fail, term_fail});
		end
		{ss_fail, term_fail, bof} = 3'h0;
		// longest echo, then one word through a peer transfer
		rx_msg(own, ROM_SA_WRAP, 32, 0, 0);
		tx_msg(ROM_SA_WRAP, 32);
		rx_msg(own, ROM_SA_WRAP, 1, 1, 0);
		tx_msg(ROM_SA_WRAP, 1);
		// pairing dropped by a count mismatch, then by a command in between
		rx_msg(own, ROM_SA_WRAP, 2, 0, 0);
		tx_msg(ROM_SA_WRAP, 3);
		rx_msg(own, ROM_SA_WRAP, 2, 0, 0);
		rx_msg(own, 5'h01, 1, 0, 0);
		tx_msg(ROM_SA_WRAP, 2);
		// a mode command in between drops the pairing as well
		rx_msg(own, ROM_SA_WRAP, 2, 0, 0);
		u_rom_bc_model.put(0, {own, 1'b1, ROM_SA_MODE_LO, 5'h02});
		pair_n = 0;
		step(2);
		tx_msg(ROM_SA_WRAP, 2);
		// broadcast against addressed to the same subaddress
		bcast_en = 1'b1;
		rx_msg(ROM_ADDR_BCAST, 5'h01, 1, 0, 0);
		chk(stat.bcast_rx, 1);
		rx_msg(own, 5'h01, 1, 0, 0);
		chk(stat.bcast_rx, 0);
		bcast_en = 1'b0;
		rx_msg(ROM_ADDR_BCAST, 5'h01, 1, 0, 0);
		chk(stat.bcast_rx, 0);
		// first data word just inside and just past the limit
		rx_msg(own, 5'h02, 1, 1, 5900);
		chk(stat.msg_err, 0);
		rx_msg(own, 5'h02, 1, 1, 6100);
		chk(stat.msg_err, 1);
		// a failed word in mid-message makes the message invalid
		rq.push_back({5'h02, 16'h1234});
		u_rom_bc_model.put(0, {own, 1'b0, 5'h02, 5'h02});
		u_rom_bc_model.put(2, 16'h1234);
		u_rom_bc_model.put(3, 16'h0000);
		step(2);
		chk(stat.msg_err, 1);
		// random counts with a slow encoder
		u_rom_bc_model.rdy_gap = 2;
		for (int i = 0; i < 6; i++) begin
			k = ($random(seed) & 31) + 1;
			rx_msg(own, ROM_SA_WRAP, k, i[0], 0);
			tx_msg(ROM_SA_WRAP, k);
			tx_msg(5'h05, k);
		end
		chk(oks, exp_oks);
		report_and_stop();
	end
endmodule : rom_msg_handler_tb_top
`default_nettype wire
